// >>> verilog/serial_port_control_consts.vh
`ifndef SERIAL_PORT_CONTROL_CONSTS_VH
`define SERIAL_PORT_CONTROL_CONSTS_VH

// Register map
`define CTRL_REG_OFFSET      12'h000
`define ADDR_LSB_WORD        2

// Field positions
`define HW_LANES_HI          31
`define HW_LANES_LO          30
`define INIT_WIDTH_HI        29
`define INIT_WIDTH_LO        27
`define FORCE_HI             26
`define FORCE_LO             24
`define LINK_OFF_BIT         23
`define TX_PKT_EN_BIT        22
`define RX_PKT_EN_BIT        21
`define ERR_CHK_OFF_BIT      20
`define MCAST_BIT            19
`define RSVD_HI              18
`define RSVD_LO              1
`define PORT_TYPE_BIT        0

// Byte lanes that hold writable fields
`define LANE_FORCE_BYTE      3
`define LANE_CTRL_BYTE       2

// Field codes
`define HW_LANES_ONE         2'h0
`define HW_LANES_FOUR        2'h1
`define INIT_ONE_LANE0       3'h0
`define INIT_ONE_LANE2       3'h1
`define INIT_FOUR            3'h2
`define FORCE_NONE           3'h0
`define FORCE_LANE0          3'h2
`define FORCE_LANE2          3'h3
`define PORT_TYPE_SERIAL     1'h1

// Reset values
`define LINK_OFF_RST         1'h0
`define TX_PKT_EN_RST        1'h1
`define RX_PKT_EN_RST        1'h1
`define ERR_CHK_OFF_RST      1'h0
`define MCAST_RST            1'h0
`define FORCE_RST            3'h0

// AXI responses
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// >>> verilog/axi_lite_word_port.v
`timescale 1ns/100ps
`include "serial_port_control_consts.vh"

module axi_lite_word_port #(
  parameter ADDR_W = 12
) (
  input  wire              clk,
  input  wire              rst,
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              awvalid,
  output reg               awready,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output reg               wready,
  output reg  [1:0]        bresp,
  output reg               bvalid,
  input  wire              bready,
  input  wire [ADDR_W-1:0] araddr,
  input  wire              arvalid,
  output reg               arready,
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  output reg               rvalid,
  input  wire              rready,
  input  wire [31:0]       rd_word,
  output wire              wr_fire,
  output wire [31:0]       wr_data,
  output wire [3:0]        wr_strb
);

  reg              aw_full_reg;
  reg              w_full_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [31:0]       w_data_reg;
  reg [3:0]        w_strb_reg;
  wire             aw_hit;
  wire             ar_hit;

  localparam [ADDR_W-1:0] REG_ADDR = `CTRL_REG_OFFSET;

  // Only the aligned word of the single register decodes; sub-word bits are ignored
  assign aw_hit  = (aw_addr_reg[ADDR_W-1:`ADDR_LSB_WORD] == REG_ADDR[ADDR_W-1:`ADDR_LSB_WORD]);
  assign ar_hit  = (araddr[ADDR_W-1:`ADDR_LSB_WORD] == REG_ADDR[ADDR_W-1:`ADDR_LSB_WORD]);
  assign wr_fire = aw_full_reg & w_full_reg & ~bvalid & aw_hit;
  assign wr_data = w_data_reg;
  assign wr_strb = w_strb_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      awready     <= 1'b0;
      wready      <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid      <= 1'b0;
      bresp       <= `RESP_OKAY;
    end else begin
      if (!aw_full_reg && !awready && !bvalid)
        awready <= 1'b1;
      if (!w_full_reg && !wready && !bvalid)
        wready <= 1'b1;
      if (awvalid && awready) begin
        aw_addr_reg <= awaddr;
        aw_full_reg <= 1'b1;
        awready     <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
        w_full_reg <= 1'b1;
        wready     <= 1'b0;
      end
      if (aw_full_reg && w_full_reg && !bvalid) begin
        bvalid      <= 1'b1;
        bresp       <= aw_hit ? `RESP_OKAY : `RESP_SLVERR;
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `RESP_OKAY;
    end else begin
      if (!arready && !rvalid)
        arready <= 1'b1;
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= ar_hit ? rd_word : 32'h00000000;
        rresp   <= ar_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

endmodule // axi_lite_word_port

// >>> verilog/serial_port_control_csr.v
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "serial_port_control_consts.vh"

// Operation
// - Hardware lane-count field read-only: 00 single-lane build, 01 four-lane build
// - Initialised-width field reports trained width: 000 lane0, 001 lane2, 010 four
// - Width-override field: 000 none, 010 force lane 0, 011 force lane 2
// - Port disabled: receivers off, drivers send idles only; resets to zero
// - Clearing the disable bit pulses forced re-initialisation of link training
// - While disabled, input buffers are kept empty until the bit clears
// - While disabled, transmit buffer is flushed and stream writes are ignored
// - Output enable low: only maintenance packets issued; resets to one
// - Input enable low: non-maintenance requests get packet-not-accepted; resets to one
// - Error-check-disable bit turns off error checking and recovery; resets zero
// - Multicast forwarding bit is plain storage with no effect; resets zero
// - Bit zero always reads one, marking a serial port
module serial_port_control_csr #(
  parameter FOUR_LANE = 0,
  parameter ADDR_W    = 12
) (
  input  wire              SYS_CLK,
  input  wire              RST,
  input  wire [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire              S_AXI_AWVALID,
  output wire              S_AXI_AWREADY,
  input  wire [31:0]       S_AXI_WDATA,
  input  wire [3:0]        S_AXI_WSTRB,
  input  wire              S_AXI_WVALID,
  output wire              S_AXI_WREADY,
  output wire [1:0]        S_AXI_BRESP,
  output wire              S_AXI_BVALID,
  input  wire              S_AXI_BREADY,
  input  wire [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire              S_AXI_ARVALID,
  output wire              S_AXI_ARREADY,
  output wire [31:0]       S_AXI_RDATA,
  output wire [1:0]        S_AXI_RRESP,
  output wire              S_AXI_RVALID,
  input  wire              S_AXI_RREADY,
  input  wire [2:0]        TRAINED_WIDTH,
  input  wire              RX_REQ_VALID,
  input  wire              RX_REQ_MAINT,
  input  wire              TX_STREAM_VALID,
  input  wire              TX_ISSUE_REQ,
  input  wire              TX_ISSUE_MAINT,
  input  wire              ERR_DETECTED,
  output reg  [2:0]        LANE_WIDTH_FORCE,
  output reg               LINK_OFF,
  output reg               RECEIVER_ENABLE,
  output reg               DRIVER_IDLE_ONLY,
  output reg               FORCE_REINIT,
  output reg               RX_BUF_FLUSH,
  output reg               TX_BUF_FLUSH,
  output reg               TX_STREAM_STORE,
  output reg               TX_PACKET_ENABLE,
  output reg               TX_ISSUE_GRANT,
  output reg               RX_PACKET_ENABLE,
  output reg               RX_REQ_ACCEPT,
  output reg               RX_REQ_NACK,
  output reg               ERROR_CHECK_OFF,
  output reg               ERR_RECOVER
);

  localparam [1:0] HW_LANES   = FOUR_LANE ? `HW_LANES_FOUR : `HW_LANES_ONE;
  localparam [2:0] INIT_RST   = FOUR_LANE ? `INIT_FOUR : `INIT_ONE_LANE0;

  wire        wr_fire;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire        force_wr;
  wire        ctrl_wr;
  wire        force_code_ok;
  reg  [31:0] rd_word;
  wire        trained_code_ok;
  wire        link_off_fall;
  wire [2:0]  wr_force_field;
  wire        wr_link_off;
  wire        wr_tx_en;
  wire        wr_rx_en;
  wire        wr_err_off;
  wire        wr_mcast;

  reg  [2:0]  init_width_reg;
  reg  [2:0]  force_reg;
  reg  [2:0]  force_next;
  reg         link_off_reg;
  reg         link_off_next;
  reg         tx_en_reg;
  reg         tx_en_next;
  reg         rx_en_reg;
  reg         rx_en_next;
  reg         err_off_reg;
  reg         err_off_next;
  reg         mcast_reg;
  reg         mcast_next;

  axi_lite_word_port #(
    .ADDR_W (ADDR_W)
  ) bus_port (
    .clk     (SYS_CLK),
    .rst     (RST),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .rd_word (rd_word),
    .wr_fire (wr_fire),
    .wr_data (wr_data),
    .wr_strb (wr_strb)
  );

  assign force_wr = wr_fire & wr_strb[`LANE_FORCE_BYTE];
  assign ctrl_wr  = wr_fire & wr_strb[`LANE_CTRL_BYTE];

  // Fields picked out of the write word once, so next-state logic reads them by name
  assign wr_force_field = wr_data[`FORCE_HI:`FORCE_LO];
  assign wr_link_off    = wr_data[`LINK_OFF_BIT];
  assign wr_tx_en       = wr_data[`TX_PKT_EN_BIT];
  assign wr_rx_en       = wr_data[`RX_PKT_EN_BIT];
  assign wr_err_off     = wr_data[`ERR_CHK_OFF_BIT];
  assign wr_mcast       = wr_data[`MCAST_BIT];

  // Reserved override codes would leave training without a defined lane, so they are dropped
  assign force_code_ok = (wr_force_field == `FORCE_NONE) ||
                         (wr_force_field == `FORCE_LANE0) ||
                         (wr_force_field == `FORCE_LANE2);

  always @* begin
    force_next = force_reg;
    if (force_wr && force_code_ok) begin
      force_next = wr_force_field;
    end
  end

  always @* begin
    link_off_next = link_off_reg;
    tx_en_next    = tx_en_reg;
    rx_en_next    = rx_en_reg;
    err_off_next  = err_off_reg;
    mcast_next    = mcast_reg;
    if (ctrl_wr) begin
      link_off_next = wr_link_off;
      tx_en_next    = wr_tx_en;
      rx_en_next    = wr_rx_en;
      err_off_next  = wr_err_off;
      mcast_next    = wr_mcast;
    end
  end

  // The override field sits in its own byte lane, so it keeps its own process
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      force_reg <= `FORCE_RST;
    end else begin
      force_reg <= force_next;
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      link_off_reg <= `LINK_OFF_RST;
      tx_en_reg    <= `TX_PKT_EN_RST;
      rx_en_reg    <= `RX_PKT_EN_RST;
      err_off_reg  <= `ERR_CHK_OFF_RST;
      mcast_reg    <= `MCAST_RST;
    end else begin
      link_off_reg <= link_off_next;
      tx_en_reg    <= tx_en_next;
      rx_en_reg    <= rx_en_next;
      err_off_reg  <= err_off_next;
      mcast_reg    <= mcast_next;
    end
  end

  // Training may show a reserved code while it settles; the last legal width is kept
  assign trained_code_ok = (TRAINED_WIDTH == `INIT_ONE_LANE0) ||
                           (TRAINED_WIDTH == `INIT_ONE_LANE2) ||
                           (TRAINED_WIDTH == `INIT_FOUR);

  // Trained width follows each legal code from the training logic; reset shows the build's full width
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      init_width_reg <= INIT_RST;
    end else begin
      init_width_reg <= trained_code_ok ? TRAINED_WIDTH : init_width_reg;
    end
  end

  always @* begin
    rd_word = 32'h00000000;
    rd_word[`HW_LANES_HI:`HW_LANES_LO]     = HW_LANES;
    rd_word[`INIT_WIDTH_HI:`INIT_WIDTH_LO] = init_width_reg;
    rd_word[`FORCE_HI:`FORCE_LO]           = force_reg;
    rd_word[`LINK_OFF_BIT]                 = link_off_reg;
    rd_word[`TX_PKT_EN_BIT]                = tx_en_reg;
    rd_word[`RX_PKT_EN_BIT]                = rx_en_reg;
    rd_word[`ERR_CHK_OFF_BIT]              = err_off_reg;
    rd_word[`MCAST_BIT]                    = mcast_reg;
    rd_word[`PORT_TYPE_BIT]                = `PORT_TYPE_SERIAL;
  end

  // Link-state levels toward the link logic, one cycle behind the register
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      LINK_OFF         <= `LINK_OFF_RST;
      RECEIVER_ENABLE  <= 1'b1;
      DRIVER_IDLE_ONLY <= 1'b0;
      RX_BUF_FLUSH     <= 1'b0;
      TX_BUF_FLUSH     <= 1'b0;
    end else begin
      LINK_OFF         <= link_off_reg;
      RECEIVER_ENABLE  <= ~link_off_reg;
      DRIVER_IDLE_ONLY <= link_off_reg;
      RX_BUF_FLUSH     <= link_off_reg;
      TX_BUF_FLUSH     <= link_off_reg;
    end
  end

  // Field mirrors; the multicast bit has no mirror since nothing may act on it
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      LANE_WIDTH_FORCE <= `FORCE_RST;
      TX_PACKET_ENABLE <= `TX_PKT_EN_RST;
      RX_PACKET_ENABLE <= `RX_PKT_EN_RST;
      ERROR_CHECK_OFF  <= `ERR_CHK_OFF_RST;
    end else begin
      LANE_WIDTH_FORCE <= force_reg;
      TX_PACKET_ENABLE <= tx_en_reg;
      RX_PACKET_ENABLE <= rx_en_reg;
      ERROR_CHECK_OFF  <= err_off_reg;
    end
  end

  // A rising edge of the disable bit does not retrain
  assign link_off_fall = link_off_reg & ~link_off_next;

  // One-cycle pulse on the falling edge of the disable bit
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      FORCE_REINIT <= 1'b0;
    end else begin
      FORCE_REINIT <= link_off_fall;
    end
  end

  // Transmit gating; decisions appear one cycle after the request
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      TX_STREAM_STORE <= 1'b0;
      TX_ISSUE_GRANT  <= 1'b0;
    end else begin
      TX_STREAM_STORE <= TX_STREAM_VALID & ~link_off_reg;
      TX_ISSUE_GRANT  <= TX_ISSUE_REQ & ~link_off_reg &
                         (tx_en_reg | TX_ISSUE_MAINT);
    end
  end

  // Receivers are off while disabled, so nothing is answered at all then
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      RX_REQ_ACCEPT <= 1'b0;
      RX_REQ_NACK   <= 1'b0;
    end else begin
      RX_REQ_ACCEPT <= RX_REQ_VALID & ~link_off_reg &
                       (rx_en_reg | RX_REQ_MAINT);
      RX_REQ_NACK   <= RX_REQ_VALID & ~link_off_reg &
                       ~rx_en_reg & ~RX_REQ_MAINT;
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ERR_RECOVER <= 1'b0;
    end else begin
      ERR_RECOVER <= ERR_DETECTED & ~err_off_reg;
    end
  end

endmodule // serial_port_control_csr

// >>> verif/serial_port_control_chk.sv
`timescale 1ns/100ps
module serial_port_control_chk #(
  parameter FOUR_LANE = 0
) (
  input wire        SYS_CLK,
  input wire        RST,
  input wire        S_AXI_RVALID,
  input wire [1:0]  S_AXI_RRESP,
  input wire [31:0] S_AXI_RDATA,
  input wire [2:0]  LANE_WIDTH_FORCE,
  input wire        LINK_OFF,
  input wire        RECEIVER_ENABLE,
  input wire        DRIVER_IDLE_ONLY,
  input wire        RX_BUF_FLUSH,
  input wire        TX_BUF_FLUSH,
  input wire        FORCE_REINIT,
  input wire        TX_STREAM_VALID,
  input wire        TX_STREAM_STORE,
  input wire        TX_ISSUE_REQ,
  input wire        TX_ISSUE_MAINT,
  input wire        TX_PACKET_ENABLE,
  input wire        TX_ISSUE_GRANT,
  input wire        RX_REQ_VALID,
  input wire        RX_REQ_MAINT,
  input wire        RX_PACKET_ENABLE,
  input wire        RX_REQ_ACCEPT,
  input wire        RX_REQ_NACK,
  input wire        ERR_DETECTED,
  input wire        ERROR_CHECK_OFF,
  input wire        ERR_RECOVER
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // Levels lag the register by a cycle, so gates are judged only over two steady samples
  chk_fixed_bits: assert property (
    S_AXI_RVALID && S_AXI_RRESP == 2'h0 |->
    S_AXI_RDATA[31:30] == (FOUR_LANE ? 2'h1 : 2'h0) && S_AXI_RDATA[0])
    else $error("fixed read bits wrong");
  chk_reserved_zero: assert property (
    S_AXI_RVALID |-> S_AXI_RDATA[18:1] == 18'h0 && S_AXI_RDATA[29:27] <= 3'h2)
    else $error("reserved or width code wrong");
  chk_force_code: assert property (LANE_WIDTH_FORCE inside {3'h0, 3'h2, 3'h3})
    else $error("reserved override code stored");
  chk_link_levels: assert property (
    RECEIVER_ENABLE == !LINK_OFF && DRIVER_IDLE_ONLY == LINK_OFF)
    else $error("receiver or driver level wrong");
  chk_reinit_edge: assert property (FORCE_REINIT |=> $fell(LINK_OFF))
    else $error("reinit without disable falling");
  chk_rx_flush: assert property (RX_BUF_FLUSH == LINK_OFF)
    else $error("input flush level wrong");
  chk_tx_drop: assert property (
    TX_STREAM_VALID && LINK_OFF ##1 LINK_OFF |-> !TX_STREAM_STORE && TX_BUF_FLUSH)
    else $error("stream write kept while off");
  chk_tx_gate: assert property (
    TX_ISSUE_REQ && !TX_ISSUE_MAINT && !TX_PACKET_ENABLE ##1 !TX_PACKET_ENABLE
    |-> !TX_ISSUE_GRANT) else $error("packet issued while output off");
  chk_rx_refuse: assert property (
    RX_REQ_VALID && !RX_REQ_MAINT && !RX_PACKET_ENABLE && !LINK_OFF
    ##1 !RX_PACKET_ENABLE && !LINK_OFF |-> RX_REQ_NACK && !RX_REQ_ACCEPT)
    else $error("request not refused");
  chk_err_gate: assert property (
    ERR_DETECTED ##1 $stable(ERROR_CHECK_OFF) |-> ERR_RECOVER == !ERROR_CHECK_OFF)
    else $error("recovery gate wrong");
endmodule // serial_port_control_chk
bind serial_port_control_csr serial_port_control_chk #(.FOUR_LANE(FOUR_LANE))
  serial_port_control_chk_i (.*);

// >>> verif/serial_link_peer.sv
`timescale 1ns/100ps
module serial_link_peer #(
  parameter WIDTH_CODE = 3'h1
) (
  input  wire       clk,
  input  wire       go,
  input  wire [1:0] kind,
  input  wire       nack,
  output reg        req_valid,
  output reg        req_maint,
  output reg        err,
  output wire [2:0] width,
  output reg  [7:0] nacks
);
  initial {req_valid, req_maint, err, nacks} = 11'h0;
  assign width = WIDTH_CODE;
  always @(posedge clk) begin
    req_valid <= go && !kind[1];
    // Qualifier wanders when idle so nobody relies on a stale value
    req_maint <= go ? kind[0] : ~req_maint;
    err <= go && kind == 2'h2;
    if (nack) nacks <= nacks + 8'h1;
  end
endmodule // serial_link_peer

// >>> verif/test_serial_port_control_csr.sv
`timescale 1ns/100ps
module test_serial_port_control_csr;
  reg         clk = 1'h0, rst = 1'h1, go = 1'h0, tsv = 1'h0, tir = 1'h0, tim = 1'h0;
  reg         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  reg  [11:0] awaddr = 12'h0, araddr = 12'h0;
  reg  [31:0] wdata = 32'h0, rd_q, cur;
  reg  [3:0]  wstrb = 4'h0;
  reg  [1:0]  kind = 2'h3, resp_q;
  reg         reinit_q;
  wire        awready, wready, bvalid, arready, rvalid, rqv, rqm, errd, lo, re, dio, reinit;
  wire        rxf, txf, store, txen, grant, rxen, acc, nack, eco, rec;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [2:0]  width, lwf;
  wire [7:0]  nacks;
  integer     num_errors = 0, n_checks = 0, i;
  always #10 clk = ~clk;
  serial_port_control_csr #(.FOUR_LANE(1)) serial_port_control_csr_i (
    .SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .TRAINED_WIDTH(width), .RX_REQ_VALID(rqv), .RX_REQ_MAINT(rqm), .TX_STREAM_VALID(tsv),
    .TX_ISSUE_REQ(tir), .TX_ISSUE_MAINT(tim), .ERR_DETECTED(errd), .LANE_WIDTH_FORCE(lwf),
    .LINK_OFF(lo), .RECEIVER_ENABLE(re), .DRIVER_IDLE_ONLY(dio), .FORCE_REINIT(reinit),
    .RX_BUF_FLUSH(rxf), .TX_BUF_FLUSH(txf), .TX_STREAM_STORE(store), .TX_PACKET_ENABLE(txen),
    .TX_ISSUE_GRANT(grant), .RX_PACKET_ENABLE(rxen), .RX_REQ_ACCEPT(acc), .RX_REQ_NACK(nack),
    .ERROR_CHECK_OFF(eco), .ERR_RECOVER(rec));
  serial_link_peer serial_link_peer_i (.clk(clk), .go(go), .kind(kind), .nack(nack),
    .req_valid(rqv), .req_maint(rqm), .err(errd), .width(width), .nacks(nacks));
  task test_done;
    begin
      $display("Checks %0d, errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task check(input string nm, input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d, input [3:0] s);
    begin
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
        @(posedge clk);
        if (awvalid && awready) awvalid <= 1'h0;
        if (wvalid && wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      reinit_q = reinit;
      resp_q = bresp;
      bready <= 1'h0;
      @(posedge clk);
    end
  endtask
  task rd(input [11:0] a);
    begin
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
        @(posedge clk);
        if (arvalid && arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rd_q = rdata;
      resp_q = rresp;
      rready <= 1'h0;
      @(posedge clk);
    end
  endtask
  // Partner request lags go by a cycle, so local stream inputs follow one edge later
  task stim(input [1:0] k, input [2:0] tx, input [4:0] exp);
    begin
      go <= 1'h1;
      kind <= k;
      @(posedge clk);
      go <= 1'h0;
      {tsv, tir, tim} <= tx;
      @(posedge clk);
      {tsv, tir, tim} <= 3'h0;
      @(posedge clk);
      check("pulses", {27'h0, store, grant, acc, nack, rec}, {27'h0, exp});
    end
  endtask
  task levels(input [7:0] exp);
    check("levels", {24'h0, lo, re, dio, rxf, txf, txen, rxen, eco}, {24'h0, exp});
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    rd(12'h000);
    check("reset word", rd_q, 32'h48600001);
    levels(8'h46);
    wr(12'h000, 32'hFFFFFFFF, 4'hF);
    check("reinit on set", {31'h0, reinit_q}, 32'h0);
    check("write resp", {30'h0, resp_q}, 32'h0);
    rd(12'h000);
    check("all ones", rd_q, 32'h48F80001);
    levels(8'hBF);
    stim(2'h0, 3'h7, 5'h00);
    stim(2'h2, 3'h0, 5'h00);
    cur = 32'h0;
    for (i = 0; i < 8; i = i + 1) begin
      wr(12'h000, i << 24, 4'h8);
      if (i == 0 || i == 2 || i == 3) cur = i;
      rd(12'h000);
      check("override", rd_q, 32'h48F80001 | (cur << 24));
      check("override out", {29'h0, lwf}, cur);
    end
    wr(12'h000, 32'h00600000, 4'h4);
    check("reinit on clear", {31'h0, reinit_q}, 32'h1);
    rd(12'h000);
    check("enabled", rd_q, 32'h4B600001);
    stim(2'h0, 3'h6, 5'h1C);
    stim(2'h2, 3'h0, 5'h01);
    wr(12'h000, 32'h00000000, 4'h4);
    stim(2'h0, 3'h2, 5'h02);
    stim(2'h1, 3'h3, 5'h0C);
    check("peer errors", {24'h0, nacks}, 32'h1);
    wr(12'h004, 32'hFFFFFFFF, 4'hF);
    check("bad addr write", {30'h0, resp_q}, 32'h2);
    rd(12'h004);
    check("bad addr read", rd_q, 32'h0);
    check("bad addr rresp", {30'h0, resp_q}, 32'h2);
    wr(12'h000, 32'hFFFFFFFF, 4'h3);
    rd(12'h000);
    check("low lanes", rd_q, 32'h4B000001);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    rd(12'h000);
    check("second reset", rd_q, 32'h48600001);
    levels(8'h46);
    test_done;
  end
  initial begin
    #100000;
    num_errors = num_errors + 1;
    test_done;
  end
endmodule // test_serial_port_control_csr
